/* design/csvf_consts.vh */
// constants of the forwarding engine: register indices, fields, resets, timing
// assumes inclusion by csvf_axil_regs.v and csvf_fwd_top.v
`ifndef CSVF_CONSTS_VH
`define CSVF_CONSTS_VH
// ---------------------------------------------------------------------------
// register indices; byte address is four times the index
// ---------------------------------------------------------------------------
`define CSVF_IDX_MAP 8'h20
`define CSVF_IDX_MODE 8'h21
`define CSVF_IDX_STAT 8'h22
`define CSVF_ADDR_MAP ({`CSVF_IDX_MAP, 2'b00})
`define CSVF_ADDR_MODE ({`CSVF_IDX_MODE, 2'b00})
`define CSVF_ADDR_STAT ({`CSVF_IDX_STAT, 2'b00})
// ---------------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------------
`define CSVF_MAP_DIS_LSB 0
`define CSVF_MAP_SEL_LSB 4
`define CSVF_MODE_RR_LSB 0
`define CSVF_MODE_SYNC_LSB 2
`define CSVF_STAT_SYNC_LSB 0
`define CSVF_STAT_LOSS_LSB 2
`define CSVF_MAP_RST 8'h00
`define CSVF_MODE_RST 8'h03
// ---------------------------------------------------------------------------
// packet kinds at a buffer head, bus responses
// ---------------------------------------------------------------------------
`define CSVF_PKT_LINE 2'h0
`define CSVF_PKT_FS 2'h1
`define CSVF_PKT_FE 2'h2
`define CSVF_RESP_OKAY 2'h0
`define CSVF_RESP_SLVERR 2'h2
// ---------------------------------------------------------------------------
// timing: alignment window of about one line period
// ---------------------------------------------------------------------------
`define CSVF_CLK_NS 20
`define CSVF_SKEW_NS 40000
`define CSVF_SKEW_CYC (`CSVF_SKEW_NS / `CSVF_CLK_NS)
`endif

/* design/csvf_axil_regs.v */
// axi4-lite register slave: map, mode and status registers of the forwarder
// assumes one clock, synchronous active-low reset and a master that obeys axi4-lite
`timescale 1ns/1ns
`include "csvf_consts.vh"
module csvf_axil_regs (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [9:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [9:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  output reg [7:0] map_q,
  output reg [7:0] mode_q,
  input wire [1:0] synced,
  input wire [1:0] loss_set
);
  reg aw_q;
  reg w_q;
  reg [9:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wstrb_q;
  reg [1:0] loss_q;
  wire rd_take;
  wire rd_stat;

  // readies are registered copies of their free conditions, so outputs leave flops
  assign rd_take = s_arvalid & s_arready;
  assign rd_stat = rd_take & (s_araddr == `CSVF_ADDR_STAT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 10'h000;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_arready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= `CSVF_RESP_OKAY;
      s_rvalid <= 1'b0;
      s_rresp <= `CSVF_RESP_OKAY;
      s_rdata <= 32'h0000_0000;
      map_q <= `CSVF_MAP_RST;
      mode_q <= `CSVF_MODE_RST;
      loss_q <= 2'h0;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_q <= 1'b1;
        s_awready <= 1'b0;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_q <= 1'b1;
        s_wready <= 1'b0;
        wdata_q <= s_wdata[7:0];
        wstrb_q <= s_wstrb[0];
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= `CSVF_RESP_OKAY;
        if (awaddr_q == `CSVF_ADDR_MAP) begin
          if (wstrb_q) map_q <= wdata_q;
        end else if (awaddr_q == `CSVF_ADDR_MODE) begin
          if (wstrb_q) mode_q <= wdata_q;
        end else if (awaddr_q != `CSVF_ADDR_STAT) begin
          s_bresp <= `CSVF_RESP_SLVERR;
        end
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
      // a loss arriving in the reading cycle survives the clear
      loss_q <= (rd_stat ? 2'h0 : loss_q) | loss_set;
      if (rd_take) begin
        s_rvalid <= 1'b1;
        s_arready <= 1'b0;
        s_rresp <= `CSVF_RESP_OKAY;
        s_rdata <= 32'h0000_0000;
        if (s_araddr == `CSVF_ADDR_MAP) begin
          s_rdata[7:0] <= map_q;
        end else if (s_araddr == `CSVF_ADDR_MODE) begin
          s_rdata[7:0] <= mode_q;
        end else if (rd_stat) begin
          s_rdata[3:0] <= {loss_q, synced};
        end else begin
          s_rresp <= `CSVF_RESP_SLVERR;
        end
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end
endmodule // csvf_axil_regs

/* design/csvf_fwd_top.v */
// forwarding engine: four receive line buffers to two csi-2 transmit ports
// assumes buffers flag a whole packet at the head and drop it on a pop pulse;
// assumes each transmitter ends a requested packet with a one-cycle done pulse
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "csvf_consts.vh"
// Function
// - move buffer packets to a transmit port as the map register says
// - drive high-speed entry and exit and pass the frame sync packets
// - look at every buffer's packet availability before each decision
// - a set disable bit keeps that input port from being forwarded
// - one map bit per buffer selects its only transmit port
// - the two engines arbitrate and are configured independently
// - default round-robin forwarding, streams told apart by vc and type
// - round-robin sends ready packets at once, rotating by input port
// - round-robin keeps each channel's own frame start and end
// - round-robin is active while the port's rotating enable bit is set and its sync mode field is zero
// - synchronized mode sends sync packets and lines in port order
// - on sync failure stop, discard, and retry at the next frame start
// - synchronized status bit plus sticky loss flag cleared by reading
// - each engine can align all four sources; any nonzero mode field enables it
// - basic synchronized keeps each stream a complete separate frame
// - all frame starts, then lines port by port, then all frame ends
// - every packet carries the vc of its receive port
// - a packet is read out only once it is whole in its buffer
// - synchronized status reads zero while sync forwarding is off
module csvf_fwd_top (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [9:0] s_awaddr,
  input wire s_awvalid,
  output wire s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output wire s_wready,
  output wire [1:0] s_bresp,
  output wire s_bvalid,
  input wire s_bready,
  input wire [9:0] s_araddr,
  input wire s_arvalid,
  output wire s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0] s_rresp,
  output wire s_rvalid,
  input wire s_rready,
  input wire [3:0] buf_avail,
  input wire [7:0] buf_kind,
  input wire [7:0] buf_vc,
  output wire [7:0] buf_pop,
  output wire [1:0] tx_req,
  output wire [3:0] tx_src,
  output wire [3:0] tx_kind,
  output wire [3:0] tx_vc,
  output wire [1:0] tx_hs,
  input wire [1:0] tx_done
);
  // ---------------------------------------------------------------------------
  // engine states
  // ---------------------------------------------------------------------------
  localparam ST_IDLE = 3'h1;
  localparam ST_SEND = 3'h2;
  localparam ST_GAP = 3'h4;
  localparam [31:0] SKEW_FULL = `CSVF_SKEW_CYC;
  // the window count fits twelve bits; the upper bits are zero by design
  localparam [11:0] SKEW_CYC = SKEW_FULL[11:0];

  wire [7:0] map_q;
  wire [7:0] mode_q;
  wire [1:0] synced;
  wire [1:0] loss;

  // next set bit of m after position c, cyclic; returns c when m is empty
  function [1:0] next_set;
    input [3:0] m;
    input [1:0] c;
    integer k;
    reg [1:0] j;
    reg [1:0] r;
    reg f;
    begin
      r = c;
      f = 1'b0;
      for (k = 1; k <= 4; k = k + 1) begin
        j = c + k[1:0];
        if (!f && m[j]) begin
          r = j;
          f = 1'b1;
        end
      end
      next_set = r;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // register slave
  // ---------------------------------------------------------------------------
  csvf_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .map_q(map_q),
    .mode_q(mode_q),
    .synced(synced),
    .loss_set(loss)
  );

  // ---------------------------------------------------------------------------
  // one engine per transmit port, sharing nothing but the registers
  // ---------------------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_eng
      reg [2:0] st_q;
      reg req_q;
      reg hs_q;
      reg [1:0] src_q;
      reg [1:0] kind_q;
      reg [1:0] vc_q;
      reg [3:0] pop_q;
      reg [1:0] last_q;
      reg synced_q;
      reg loss_q;
      reg [1:0] cur_q;
      reg [1:0] phase_q;
      reg [11:0] cnt_q;
      reg [3:0] member;
      reg [3:0] elig;
      reg [3:0] fs_ok;
      reg [1:0] head;
      reg [1:0] first;
      reg [1:0] after;
      reg sync_on;
      reg rr_on;
      reg [1:0] rr_pick;
      reg [1:0] drop_pick;
      reg [1:0] stale_pick;
      integer i;

      // -----------------------------------------------------------------------
      // per-engine selection
      // -----------------------------------------------------------------------
      // port selection, derived afresh every cycle from buffers and registers
      always @* begin
        member = 4'h0;
        fs_ok = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
          member[i] = ~map_q[`CSVF_MAP_DIS_LSB + i] &
            (map_q[`CSVF_MAP_SEL_LSB + i] == t);
          fs_ok[i] = buf_avail[i] & (buf_kind[2 * i +: 2] == `CSVF_PKT_FS);
        end
        elig = member & buf_avail;
        sync_on = mode_q[`CSVF_MODE_SYNC_LSB + 2 * t +: 2] != 2'h0;
        // synchronized selection outranks the rotating enable
        rr_on = mode_q[`CSVF_MODE_RR_LSB + t] & ~sync_on;
        head = buf_kind[{cur_q, 1'b0} +: 2];
        first = next_set(member, 2'h3);
        after = next_set(member, cur_q);
        // one picker per decision keeps the served port and its fields consistent
        rr_pick = next_set(elig, last_q);
        drop_pick = next_set(elig & ~fs_ok, 2'h3);
        stale_pick = next_set(fs_ok & member, 2'h3);
      end

      // -----------------------------------------------------------------------
      // engine sequencer
      // -----------------------------------------------------------------------
      always @(posedge aclk) begin
        if (!aresetn) begin
          st_q <= ST_IDLE;
          req_q <= 1'b0;
          hs_q <= 1'b0;
          src_q <= 2'h0;
          kind_q <= `CSVF_PKT_LINE;
          vc_q <= 2'h0;
          pop_q <= 4'h0;
          last_q <= 2'h3;
          synced_q <= 1'b0;
          loss_q <= 1'b0;
          cur_q <= 2'h0;
          phase_q <= `CSVF_PKT_FS;
          cnt_q <= 12'h000;
        end else if (ce) begin
          pop_q <= 4'h0;
          loss_q <= 1'b0;
          case (st_q)
            ST_IDLE: begin
              if (!sync_on) begin
                synced_q <= 1'b0;
                cnt_q <= 12'h000;
                if (rr_on && (elig != 4'h0)) begin
                  // any packet kind goes, so frame starts and ends stay per vc
                  src_q <= rr_pick;
                  last_q <= rr_pick;
                  kind_q <= buf_kind[{rr_pick, 1'b0} +: 2];
                  vc_q <= buf_vc[{rr_pick, 1'b0} +: 2];
                  req_q <= 1'b1;
                  hs_q <= 1'b1;
                  st_q <= ST_SEND;
                end else begin
                  hs_q <= 1'b0;
                end
              end else if (!synced_q) begin
                hs_q <= 1'b0;
                if ((member != 4'h0) && ((fs_ok | ~member) == 4'hF)) begin
                  // every enabled source stands at a frame start: lock
                  synced_q <= 1'b1;
                  cur_q <= first;
                  phase_q <= `CSVF_PKT_FS;
                  cnt_q <= 12'h000;
                end else if ((elig & ~fs_ok) != 4'h0) begin
                  src_q <= drop_pick;
                  pop_q[drop_pick] <= 1'b1;
                  st_q <= ST_GAP;
                end else if ((fs_ok & member) != 4'h0) begin
                  // a frame start that waits beyond the window is stale
                  if (cnt_q >= SKEW_CYC) begin
                    pop_q[stale_pick] <= 1'b1;
                    cnt_q <= 12'h000;
                    st_q <= ST_GAP;
                  end else begin
                    cnt_q <= cnt_q + 12'h001;
                  end
                end else begin
                  cnt_q <= 12'h000;
                end
              end else if (member[cur_q] && buf_avail[cur_q]) begin
                cnt_q <= 12'h000;
                if ((head == phase_q) ||
                    ((cur_q == first) && (phase_q == `CSVF_PKT_LINE) &&
                     (head == `CSVF_PKT_FE))) begin
                  if (head == `CSVF_PKT_FE) phase_q <= `CSVF_PKT_FE;
                  src_q <= cur_q;
                  kind_q <= head;
                  vc_q <= buf_vc[{cur_q, 1'b0} +: 2];
                  req_q <= 1'b1;
                  hs_q <= 1'b1;
                  st_q <= ST_SEND;
                end else begin
                  synced_q <= 1'b0;
                  loss_q <= 1'b1;
                end
              end else if (!member[cur_q]) begin
                // membership changed under the lock: start over
                synced_q <= 1'b0;
                loss_q <= 1'b1;
              end else if ((cur_q != first) || (phase_q != `CSVF_PKT_FS)) begin
                hs_q <= 1'b0;
                if (cnt_q >= SKEW_CYC) begin
                  synced_q <= 1'b0;
                  loss_q <= 1'b1;
                  cnt_q <= 12'h000;
                end else begin
                  cnt_q <= cnt_q + 12'h001;
                end
              end else begin
                // frame blanking between frames, no window applies
                hs_q <= 1'b0;
              end
            end
            ST_SEND: begin
              if (tx_done[t]) begin
                req_q <= 1'b0;
                pop_q[src_q] <= 1'b1;
                st_q <= ST_GAP;
                if (synced_q) begin
                  if (after <= cur_q) begin
                    cur_q <= first;
                    if (phase_q == `CSVF_PKT_FS) phase_q <= `CSVF_PKT_LINE;
                    if (phase_q == `CSVF_PKT_FE) phase_q <= `CSVF_PKT_FS;
                  end else begin
                    cur_q <= after;
                  end
                end
              end
            end
            ST_GAP: begin
              // one cycle for the buffer to retire the popped head
              st_q <= ST_IDLE;
            end
            default: begin
              st_q <= ST_IDLE;
              req_q <= 1'b0;
            end
          endcase
        end
      end

      // -----------------------------------------------------------------------
      // engine outputs, each straight from its flop except synced, which is gated by sync_on
      // -----------------------------------------------------------------------
      assign buf_pop[4 * t +: 4] = pop_q;
      assign tx_req[t] = req_q;
      assign tx_src[2 * t +: 2] = src_q;
      assign tx_kind[2 * t +: 2] = kind_q;
      assign tx_vc[2 * t +: 2] = vc_q;
      assign tx_hs[t] = hs_q;
      assign synced[t] = synced_q & sync_on;
      assign loss[t] = loss_q;
    end
  endgenerate
endmodule // csvf_fwd_top

/* tb/csvf_tx_model.sv */
// far-side model of the two csi-2 transmitters: ends each requested packet
// assumes tx_req stays high until the done pulse; dly comes from the bench
`timescale 1ns/1ns
module csvf_tx_model (
  input wire aclk,
  input wire aresetn,
  input wire [1:0] tx_req,
  input wire [3:0] dly,
  output reg [1:0] tx_done = 2'b00
);
  reg [3:0] cnt_q [0:1];
  integer t;
  // one pulse per packet, then silent until the next request is seen
  always @(posedge aclk) begin
    for (t = 0; t < 2; t = t + 1) begin
      if (!aresetn || tx_done[t]) begin
        tx_done[t] <= 1'b0;
        cnt_q[t] <= 4'h0;
      end else if (tx_req[t] && cnt_q[t] >= dly) begin
        tx_done[t] <= 1'b1;
      end else if (tx_req[t]) begin
        cnt_q[t] <= cnt_q[t] + 4'h1;
      end
    end
  end
endmodule // csvf_tx_model

/* tb/csvf_fwd_top_sva.sv */
// checker of the forwarding engine ports, bound to csvf_fwd_top
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ns
module csvf_fwd_top_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_awvalid,
  input wire s_awready,
  input wire s_wvalid,
  input wire s_wready,
  input wire s_bvalid,
  input wire s_arvalid,
  input wire s_arready,
  input wire s_rvalid,
  input wire [3:0] buf_avail,
  input wire [7:0] buf_vc,
  input wire [7:0] buf_pop,
  input wire [1:0] tx_req,
  input wire [3:0] tx_src,
  input wire [3:0] tx_kind,
  input wire [3:0] tx_vc,
  input wire [1:0] tx_hs,
  input wire [1:0] tx_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence resp_late;
    !s_bvalid ##1 s_bvalid;
  endsequence
  sequence end0;
    tx_req[0] && tx_done[0];
  endsequence
  chk_write_resp: assert property (both_taken |=> resp_late)
    else $error("write response not two cycles after address and data");
  chk_read_resp: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read data not one cycle after address");
  chk_pop_tx0: assert property (end0 |=> buf_pop[3:0] == (4'h1 << $past(tx_src[1:0])))
    else $error("engine 0 popped the wrong buffer");
  chk_pop_tx1: assert property (tx_req[1] && tx_done[1] |=>
    buf_pop[7:4] == (4'h1 << $past(tx_src[3:2])))
    else $error("engine 1 popped the wrong buffer");
  chk_gap_tx0: assert property (end0 |=> !tx_req[0] [*2])
    else $error("engine 0 request too soon after done");
  chk_req_steady: assert property (tx_req[0] && !tx_done[0] |=>
    tx_req[0] && $stable(tx_src[1:0]) && $stable(tx_kind[1:0]))
    else $error("engine 0 request changed before done");
  chk_hs_burst: assert property ((tx_req & ~tx_hs) == 2'b00)
    else $error("request outside high-speed burst");
  chk_whole_pkt: assert property ($rose(tx_req[0]) |->
    (($past(buf_avail) >> tx_src[1:0]) & 4'h1) == 4'h1)
    else $error("request for a buffer without a whole packet");
  chk_vc_kept: assert property (tx_req[0] |->
    {6'h00, tx_vc[1:0]} == ((buf_vc >> {tx_src[1:0], 1'b0}) & 8'h03))
    else $error("virtual channel differs from its receive port");
endmodule // csvf_fwd_top_sva
bind csvf_fwd_top csvf_fwd_top_sva chk_u (.*);

/* tb/csvf_fwd_top_tb.sv */
// self-checking bench: queue model of four buffers, rotating and aligned model
// assumes csvf_fwd_top, csvf_tx_model and the bound checker are compiled first
`timescale 1ns/1ns
`include "csvf_consts.vh"
module csvf_fwd_top_tb;
  localparam int LN = `CSVF_PKT_LINE, FS = `CSVF_PKT_FS, FE = `CSVF_PKT_FE;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg ce = 1'b1;
  reg [9:0] s_awaddr = 10'h000, s_araddr = 10'h000;
  reg [31:0] s_wdata = 32'h0;
  reg [3:0] s_wstrb = 4'hF;
  reg s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  reg [3:0] buf_avail = 4'h0;
  reg [7:0] buf_kind = 8'h00;
  wire [7:0] buf_vc = 8'hE4;
  wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  wire [1:0] s_bresp, s_rresp, tx_req, tx_hs, tx_done;
  wire [31:0] s_rdata;
  wire [7:0] buf_pop;
  wire [3:0] tx_src, tx_kind, tx_vc;
  reg [3:0] dly = 4'h0;
  reg [7:0] map_m = 8'h00, mode_m = 8'h03, d;
  integer bad_count = 0, tests_run = 0, cyc = 0, sent = 0, i, t, p, e, seen;
  int q [4][$];
  int exp_q [$];
  int last [2] = '{3, 3};
  always #10 aclk = ~aclk;
  csvf_fwd_top dut_u (.*);
  csvf_tx_model tx_u (.aclk(aclk), .aresetn(aresetn), .tx_req(tx_req), .dly(dly),
    .tx_done(tx_done));
  task check(input [31:0] s, input [31:0] x);
    tests_run = tests_run + 1;
    if (s !== x) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task summarize;
    $display("mismatches %0d checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // next eligible buffer after the last one served, as the rotating engine sees it
  function int pick(int n);
    for (int k = 1; k < 5; k++) begin
      pick = (last[n] + k) % 4;
      if (q[pick].size() > 0 && map_m[4 + pick] == n && !map_m[pick] && mode_m[n]) return pick;
    end
    return -1;
  endfunction
  // -------------------------------------------------------------------------
  // buffers and result monitor
  // -------------------------------------------------------------------------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      bad_count = bad_count + 1;
      summarize;
    end
    for (t = 0; t < 2; t = t + 1) if (aresetn && tx_req[t] === 1'b1 && tx_done[t] === 1'b1) begin
      seen = {tx_src[2*t +: 2], tx_kind[2*t +: 2], tx_vc[2*t +: 2]};
      if (mode_m[2 + 2*t +: 2] != 2'b00) begin
        e = exp_q.pop_front();
        check(seen, e);
      end else begin
        p = pick(t);
        e = (p < 0) ? 'hFF : (p << 4) | (q[p][0] << 2) | p;
        check(seen, e);
        if (p >= 0) last[t] = p;
      end
      sent = sent + 1;
      dly <= $urandom_range(6);
    end
    for (i = 0; i < 4; i = i + 1) begin
      if ((buf_pop[i] | buf_pop[4 + i]) && q[i].size() > 0) void'(q[i].pop_front());
      buf_avail[i] <= q[i].size() > 0;
      buf_kind[2*i +: 2] <= (q[i].size() > 0) ? q[i][0] : 0;
    end
  end
  task axi_wr(input [9:0] a, input [31:0] x, input [1:0] er);
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= x;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!(s_bvalid && s_bready));
    s_bready <= 1'b0;
    check(s_bresp, er);
  endtask
  task axi_rd(input [9:0] a, input [31:0] x, input [31:0] m, input [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!(s_rvalid && s_rready));
    s_rready <= 1'b0;
    check(s_rdata & m, x);
    check(s_rresp, er);
  endtask
  task set_map(input [7:0] x);
    axi_wr(`CSVF_ADDR_MAP, x, `CSVF_RESP_OKAY);
    map_m = x;
  endtask
  task set_mode(input [7:0] x);
    axi_wr(`CSVF_ADDR_MODE, x, `CSVF_RESP_OKAY);
    mode_m = x;
  endtask
  task load(int b, int k, int n);
    repeat (n) q[b].push_back(k);
  endtask
  task drain;
    do @(posedge aclk);
    while (q[0].size() + q[1].size() + q[2].size() + q[3].size() != 0 || tx_req !== 2'b00);
    repeat (6) @(posedge aclk);
  endtask
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    void'($urandom(27471));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`CSVF_ADDR_MAP, 32'h00, 32'hFF, `CSVF_RESP_OKAY);
    axi_rd(`CSVF_ADDR_MODE, 32'h03, 32'hFF, `CSVF_RESP_OKAY);
    axi_rd(`CSVF_ADDR_STAT, 32'h00, 32'hFF, `CSVF_RESP_OKAY);
    axi_rd(10'h000, 32'h0, 32'hFFFFFFFF, `CSVF_RESP_SLVERR);
    axi_wr(10'h004, 32'h1, `CSVF_RESP_SLVERR);
    axi_wr(`CSVF_ADDR_STAT, 32'hFF, `CSVF_RESP_OKAY);
    axi_rd(`CSVF_ADDR_STAT, 32'h00, 32'hFF, `CSVF_RESP_OKAY);
    @(negedge aclk);
    load(0, LN, 3); load(1, LN, 1); load(2, FS, 1); load(3, FE, 1);
    drain;
    check(sent, 6);
    d = $urandom_range(14, 1);
    set_map(d);
    sent = 0;
    @(negedge aclk);
    for (i = 0; i < 4; i = i + 1) load(i, LN, 1);
    repeat (80) @(posedge aclk);
    check(sent, 4 - $countones(d[3:0]));
    for (i = 0; i < 4; i = i + 1) check(q[i].size(), d[i]);
    set_map(8'h00);
    drain;
    set_map(8'hA0);
    @(negedge aclk);
    for (i = 0; i < 4; i = i + 1) load(i, LN, 2);
    drain;
    set_mode(8'h01);
    @(negedge aclk);
    load(0, LN, 1); load(1, LN, 1);
    repeat (60) @(posedge aclk);
    check(q[1].size(), 1);
    check(q[0].size(), 0);
    set_mode(8'h03);
    drain;
    // enabling order: rotating off, inputs on, then aligned select
    set_mode(8'h00);
    set_map(8'h00);
    set_mode(8'h04);
    @(negedge aclk);
    // aligned sources: same line count and sync packets on every enabled port
    for (i = 0; i < 4; i = i + 1) begin
      load(i, FS, 1); load(i, LN, 2); load(i, FE, 1);
      exp_q.push_back((i << 4) | (FS << 2) | i);
    end
    for (t = 0; t < 2; t = t + 1) for (i = 0; i < 4; i = i + 1) exp_q.push_back((i << 4) | i);
    for (i = 0; i < 4; i = i + 1) exp_q.push_back((i << 4) | (FE << 2) | i);
    drain;
    axi_rd(`CSVF_ADDR_STAT, 32'h1, 32'h3, `CSVF_RESP_OKAY);
    set_mode(8'h00);
    axi_rd(`CSVF_ADDR_STAT, 32'h0, 32'h3, `CSVF_RESP_OKAY);
    set_map(8'h0C);
    set_mode(8'h04);
    axi_rd(`CSVF_ADDR_STAT, 32'h0, 32'h3, `CSVF_RESP_OKAY);
    // a frame start where a line belongs breaks the lock mid-round
    @(negedge aclk);
    load(0, FS, 1); load(0, LN, 1); load(1, FS, 2);
    exp_q.push_back(FS << 2);
    exp_q.push_back((1 << 4) | (FS << 2) | 1);
    exp_q.push_back(0);
    drain;
    check(exp_q.size(), 0);
    axi_rd(`CSVF_ADDR_STAT, 32'h4, 32'hF, `CSVF_RESP_OKAY);
    axi_rd(`CSVF_ADDR_STAT, 32'h0, 32'hF, `CSVF_RESP_OKAY);
    summarize;
  end
endmodule // csvf_fwd_top_tb
